//--- src/spss_pkg.sv
// Shared constants and types for the sensor power and standby sequencer.
package spss_pkg;

   // ==========================================================================
   // Clock and timing.
   // ==========================================================================
   localparam int unsigned CLK_PERIOD_PS      = 5000;
   localparam int unsigned BUS_WAIT_REF_CYC   = 8192;
   localparam int unsigned QUIET_REF_CYC      = 512;
   localparam int unsigned REG_SETTLE_US      = 1000;
   localparam int unsigned PLL_LOCK_US        = 200;
   localparam int unsigned STREAM_FIXED_US    = 10000;
   localparam int unsigned RESET_SETTLE_US    = 2000;
   localparam int unsigned POR_CYC            = 16;
   // Cycle counts derived from the times above (least times round up; STREAM_FIXED_US * 1000000 overflows 32 bits and wraps).
   localparam int unsigned REG_SETTLE_CYC  = (REG_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
   localparam int unsigned PLL_LOCK_CYC    = (PLL_LOCK_US * 1000000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
   localparam int unsigned STREAM_FIXED_CYC = (STREAM_FIXED_US * 1000000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
   localparam int unsigned RESET_SETTLE_CYC = (RESET_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;

   // ==========================================================================
   // Widths and reset values.
   // ==========================================================================
   localparam int unsigned CNT_W   = 24;
   localparam int unsigned EXPO_W  = 16;
   localparam logic [EXPO_W-1:0] EXPO_RST = 16'h0010;
   localparam int unsigned LINE_CYC = 64;

   // General-purpose pin modes allowed in standby.
   typedef enum logic [1:0] {
      SPSS_GPIO_FLOAT = 2'h0,
      SPSS_GPIO_LOW   = 2'h1,
      SPSS_GPIO_HIGH  = 2'h2
   } spss_gpio_t;

endpackage : spss_pkg

//--- src/spss_if.sv
// Link between the host controller end and the sensor end.
`timescale 1ns/10ps
`default_nettype none
interface spss_if;
   logic       shutdown_n;     // Active-low hard reset / shutdown pin.
   logic       powerdown_n;    // Active-low power-down pin.
   logic       ref_clk_en;     // Reference clock running (input_ref_clock gate).
   logic       bus_valid;      // One serial_control_bus transaction pulse.
   logic       bus_stream;     // Streaming request carried by the transaction.
   logic [1:0] bus_gpio;       // Standby pin mode carried by the transaction.
   logic [15:0] bus_expo;      // Exposure lines carried by the transaction.
   logic       frame_active;   // Device is sending a frame.
   logic       frame_end;      // Pulse: frame end code sent.

   modport host (output shutdown_n, output powerdown_n, output ref_clk_en,
                 output bus_valid, output bus_stream, output bus_gpio, output bus_expo,
                 input frame_active, input frame_end);
   modport dev  (input shutdown_n, input powerdown_n, input ref_clk_en,
                 input bus_valid, input bus_stream, input bus_gpio, input bus_expo,
                 output frame_active, output frame_end);
endinterface : spss_if
`default_nettype wire

//--- src/spss_cnt.sv
// Loadable down counter used for the sequencing waits.
`timescale 1ns/10ps
`default_nettype none
module spss_cnt
   import spss_pkg::*;
#(
   parameter int unsigned W = CNT_W
) (
   input  wire logic         clk_sys,
   input  wire logic         reset_n,
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   input  wire logic         tick,
   output logic              done
);
   logic [W-1:0] cnt_q;

   // ==========================================================================
   // Counter.
   // ==========================================================================
   // Load wins over counting so a restart is never lost.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= value;
      end else if (tick && cnt_q != '0) begin
         cnt_q <= cnt_q - W'(1);
      end
   end

   // Done is registered so it lags the last count by one cycle.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         done <= 1'b0;
      end else begin
         done <= !load && (cnt_q == '0);
      end
   end
endmodule : spss_cnt
`default_nettype wire

//--- src/spss_dev.sv
// Sensor end: reset, standby and streaming entry/exit sequencing.
`timescale 1ns/10ps
`default_nettype none
module spss_dev
   import spss_pkg::*;
#(
   parameter int unsigned FIXED_CYC = STREAM_FIXED_CYC,
   parameter int unsigned LINE_LEN  = LINE_CYC,
   parameter int unsigned FRAME_LINES = 8
) (
   input  wire logic clk_sys,
   input  wire logic reset_n,
   spss_if.dev       lnk,
   input  wire logic core_supply_ok,
   output logic      streaming,
   output logic      sw_standby,
   output logic      hw_standby,
   output logic      regs_default,
   output logic      gpio_o,
   output logic      gpio_oe
);
   typedef enum logic [2:0] {
      SPSS_ST_POR, SPSS_ST_STBY, SPSS_ST_FIXED, SPSS_ST_EXPO, SPSS_ST_STREAM, SPSS_ST_DRAIN
   } spss_st_t;

   spss_st_t        st_q;
   logic [1:0]      shd_s_q, pwd_s_q, cor_s_q;
   logic            shd_n, pwd_n, core_ok;
   logic            stream_req_q;
   spss_gpio_t      gpio_mode_q;
   logic [EXPO_W-1:0] expo_q;
   logic [7:0]      por_q;
   logic            alive;
   logic            bus_ok;
   logic [15:0]     line_q;
   logic [15:0]     lines_q;
   logic            line_tick;
   logic            cnt_load, cnt_done;
   logic [CNT_W-1:0] cnt_val;
   logic [15:0]     fline_q;
   logic            frame_q, fend_q;

   // ==========================================================================
   // Pin synchronisers.
   // ==========================================================================
   // Pins come from the other party, so each passes two flip-flops first.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         shd_s_q <= 2'h0;
         pwd_s_q <= 2'h0;
         cor_s_q <= 2'h0;
      end else begin
         shd_s_q <= {shd_s_q[0], lnk.shutdown_n};
         pwd_s_q <= {pwd_s_q[0], lnk.powerdown_n};
         cor_s_q <= {cor_s_q[0], core_supply_ok};
      end
   end
   assign shd_n   = shd_s_q[1];
   assign pwd_n   = pwd_s_q[1];
   assign core_ok = cor_s_q[1];

   // ==========================================================================
   // Internal power-on reset.
   // ==========================================================================
   // Counts stable core supply, independent of the shutdown pin.
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !core_ok) begin
         por_q <= 8'h00;
      end else if (por_q != 8'(POR_CYC)) begin
         por_q <= por_q + 8'h01;
      end
   end
   assign alive  = (por_q == 8'(POR_CYC)) && shd_n;
   // The bus is only heard when neither pin holds the part in standby.
   assign bus_ok = alive && pwd_n && lnk.ref_clk_en && lnk.bus_valid;

   // ==========================================================================
   // Register state (streaming request, pin mode, exposure).
   // ==========================================================================
   // Shutdown low returns defaults; power-down low only freezes the values.
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !alive) begin
         stream_req_q <= 1'b0;
         gpio_mode_q  <= SPSS_GPIO_FLOAT;
         expo_q       <= EXPO_RST;
      end else if (bus_ok) begin
         stream_req_q <= lnk.bus_stream;
         gpio_mode_q  <= spss_gpio_t'(lnk.bus_gpio);
         expo_q       <= lnk.bus_expo;
      end
   end

   // ==========================================================================
   // Line timebase.
   // ==========================================================================
   // One-cycle enable per line; only runs while the power-down pin is high.
   always_ff @(posedge clk_sys) begin
      if (!reset_n || st_q == SPSS_ST_STBY || st_q == SPSS_ST_POR) begin
         line_q <= 16'h0000;
      end else if (pwd_n) begin
         line_q <= (line_q == 16'(LINE_LEN - 1)) ? 16'h0000 : line_q + 16'h0001;
      end
   end
   assign line_tick = pwd_n && (line_q == 16'(LINE_LEN - 1));

   // Wait counter: fixed delay first, then exposure lines.
   assign cnt_load = (st_q == SPSS_ST_STBY && stream_req_q) ||
                     (st_q == SPSS_ST_FIXED && cnt_done);
   assign cnt_val  = (st_q == SPSS_ST_STBY) ? CNT_W'(FIXED_CYC) : CNT_W'(expo_q);

   spss_cnt #(.W(CNT_W)) u_wait (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .load    (cnt_load),
      .value   (cnt_val),
      .tick    ((st_q == SPSS_ST_FIXED && pwd_n) || (st_q == SPSS_ST_EXPO && line_tick)),
      .done    (cnt_done)
   );

   // ==========================================================================
   // Mode sequencer.
   // ==========================================================================
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !alive) begin
         st_q <= SPSS_ST_POR;
      end else begin
         case (st_q)
            SPSS_ST_POR: begin
               st_q <= SPSS_ST_STBY;
            end
            SPSS_ST_STBY: begin
               if (stream_req_q) begin
                  st_q <= SPSS_ST_FIXED;
               end
            end
            SPSS_ST_FIXED: begin
               if (!stream_req_q) begin
                  st_q <= SPSS_ST_STBY;
               end else if (cnt_done) begin
                  st_q <= SPSS_ST_EXPO;
               end
            end
            SPSS_ST_EXPO: begin
               if (!stream_req_q) begin
                  st_q <= SPSS_ST_STBY;
               end else if (cnt_done) begin
                  st_q <= SPSS_ST_STREAM;
               end
            end
            SPSS_ST_STREAM: begin
               if (!stream_req_q) begin
                  // Mid-frame stop drains; between frames stop at once.
                  st_q <= frame_q ? SPSS_ST_DRAIN : SPSS_ST_STBY;
               end
            end
            SPSS_ST_DRAIN: begin
               if (fend_q) begin
                  st_q <= SPSS_ST_STBY;
               end
            end
            default: begin
               st_q <= SPSS_ST_POR;
            end
         endcase
      end
   end

   // ==========================================================================
   // Frame generator.
   // ==========================================================================
   // A frame lasts FRAME_LINES lines; a new one starts only while streaming.
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !alive) begin
         frame_q <= 1'b0;
         fend_q  <= 1'b0;
         fline_q <= 16'h0000;
      end else begin
         fend_q <= 1'b0;
         if (line_tick) begin
            if (frame_q) begin
               if (fline_q == 16'(FRAME_LINES - 1)) begin
                  frame_q <= 1'b0;
                  fend_q  <= 1'b1;
                  fline_q <= 16'h0000;
               end else begin
                  fline_q <= fline_q + 16'h0001;
               end
            end else if (st_q == SPSS_ST_STREAM && stream_req_q) begin
               frame_q <= 1'b1;
            end
         end
      end
   end
   assign lnk.frame_active = frame_q;
   assign lnk.frame_end    = fend_q;

   // ==========================================================================
   // Status outputs.
   // ==========================================================================
   // All outputs are registered; the pin floats outside standby by choice.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         streaming    <= 1'b0;
         sw_standby   <= 1'b0;
         hw_standby   <= 1'b1;
         regs_default <= 1'b1;
         gpio_o       <= 1'b0;
         gpio_oe      <= 1'b0;
      end else begin
         streaming    <= alive && pwd_n && st_q != SPSS_ST_STBY && st_q != SPSS_ST_POR;
         sw_standby   <= alive && pwd_n && st_q inside {SPSS_ST_POR, SPSS_ST_STBY};
         hw_standby   <= !alive || !pwd_n;
         regs_default <= !alive;
         gpio_o       <= (gpio_mode_q == SPSS_GPIO_HIGH);
         gpio_oe      <= (gpio_mode_q != SPSS_GPIO_FLOAT) &&
                         (!pwd_n || st_q == SPSS_ST_STBY);
      end
   end
endmodule : spss_dev
`default_nettype wire

//--- src/spss_host.sv
// Host end: drives the control pins and bus requests with the required waits.
`timescale 1ns/10ps
`default_nettype none
module spss_host
   import spss_pkg::*;
#(
   parameter int unsigned BOOT_CYC = BUS_WAIT_REF_CYC + REG_SETTLE_CYC + PLL_LOCK_CYC
                                     + RESET_SETTLE_CYC,
   parameter int unsigned QUIET_CYC = QUIET_REF_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   spss_if.host             lnk,
   input  wire logic        supplies_ok,
   input  wire logic        power_on,
   input  wire logic        req_valid,
   input  wire logic        req_stream,
   input  wire logic [1:0]  req_gpio,
   input  wire logic [15:0] req_expo,
   output logic             req_ready
);
   typedef enum logic [2:0] {
      SPSS_H_OFF, SPSS_H_BOOT, SPSS_H_READY, SPSS_H_QUIET
   } spss_hst_t;

   spss_hst_t st_q;
   logic [1:0] sup_s_q;
   logic       sup_ok;
   logic       ld, done;
   logic       shd_q, clk_q, bv_q, bs_q;
   logic [1:0] bg_q;
   logic [15:0] be_q;
   logic       issue;

   // Supply status is a pin, so it is synchronised.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         sup_s_q <= 2'h0;
      end else begin
         sup_s_q <= {sup_s_q[0], supplies_ok};
      end
   end
   assign sup_ok = sup_s_q[1];
   assign issue  = (st_q == SPSS_H_READY) && req_valid && req_ready;

   // Boot wait covers 8192 cycles, regulator, PLL and settling in one count.
   assign ld = (st_q == SPSS_H_OFF && power_on && sup_ok) ||
               (st_q == SPSS_H_QUIET && lnk.frame_end) ||
               (st_q == SPSS_H_READY && !power_on);

   spss_cnt #(.W(CNT_W)) u_wait (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .load    (ld),
      .value   ((st_q == SPSS_H_OFF) ? CNT_W'(BOOT_CYC) : CNT_W'(QUIET_CYC)),
      .tick    (1'b1),
      .done    (done)
   );

   // ==========================================================================
   // Pin sequencer.
   // ==========================================================================
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         st_q  <= SPSS_H_OFF;
         shd_q <= 1'b0;
         clk_q <= 1'b0;
      end else begin
         case (st_q)
            SPSS_H_OFF: begin
               if (power_on && sup_ok) begin
                  shd_q <= 1'b1;
                  clk_q <= 1'b1;
                  st_q  <= SPSS_H_BOOT;
               end
            end
            SPSS_H_BOOT: begin
               if (!sup_ok) begin
                  shd_q <= 1'b0;
                  st_q  <= SPSS_H_OFF;
               end else if (done) begin
                  st_q <= SPSS_H_READY;
               end
            end
            SPSS_H_READY: begin
               if (!sup_ok) begin
                  shd_q <= 1'b0;
                  st_q  <= SPSS_H_OFF;
               end else if (!power_on) begin
                  st_q <= SPSS_H_QUIET;
               end
            end
            SPSS_H_QUIET: begin
               // A frame end reloads the quiet count.
               if (!sup_ok || (done && !lnk.frame_active)) begin
                  shd_q <= 1'b0;
                  clk_q <= 1'b0;
                  st_q  <= SPSS_H_OFF;
               end
            end
            default: begin
               st_q <= SPSS_H_OFF;
            end
         endcase
      end
   end

   // Bus requests: one-cycle pulse, back-to-back refused by ready.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         bv_q      <= 1'b0;
         bs_q      <= 1'b0;
         bg_q      <= 2'h0;
         be_q      <= 16'h0000;
         req_ready <= 1'b0;
      end else begin
         bv_q      <= issue;
         req_ready <= (st_q == SPSS_H_READY) && !issue;
         if (issue) begin
            bs_q <= req_stream;
            bg_q <= req_gpio;
            be_q <= req_expo;
         end
      end
   end

   assign lnk.shutdown_n  = shd_q;
   assign lnk.powerdown_n = 1'b1;
   assign lnk.ref_clk_en  = clk_q;
   assign lnk.bus_valid   = bv_q;
   assign lnk.bus_stream  = bs_q;
   assign lnk.bus_gpio    = bg_q;
   assign lnk.bus_expo    = be_q;
endmodule : spss_host
`default_nettype wire

//--- test/spss_assertions.sv
// Concurrent checks on the link between the host end and the sensor end.
`timescale 1ns/10ps
`default_nettype none
module spss_assertions #(
   parameter int unsigned BOOT_CYC  = 40,
   parameter int unsigned QUIET_CYC = 8,
   parameter int unsigned FIXED_CYC = 50,
   parameter int unsigned LINE_LEN  = 4
) (
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic        shutdown_n,
   input wire logic        powerdown_n,
   input wire logic        ref_clk_en,
   input wire logic        bus_valid,
   input wire logic        bus_stream,
   input wire logic [1:0]  bus_gpio,
   input wire logic [15:0] bus_expo,
   input wire logic        frame_active,
   input wire logic        frame_end
);
   // Slack for the line tick after the waits.
   localparam int unsigned LATE_SLACK = 2 * LINE_LEN + 16;
   logic [31:0] boot_q;
   logic [31:0] quiet_q;
   logic [31:0] wait_q;
   logic [31:0] lim_q;
   logic        armed_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   // ==========================================================================
   // Helper counters.
   // ==========================================================================
   // Cycles since shutdown rose; saturates.
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !shutdown_n) boot_q <= '0;
      else if (boot_q != 32'hFFFFFFFF) boot_q <= boot_q + 32'h1;
   end
   // Cycles since the last bus transaction or frame end; idle counts as quiet.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) quiet_q <= 32'hFFFFFFFF;
      else if (bus_valid || frame_end) quiet_q <= '0;
      else if (quiet_q != 32'hFFFFFFFF) quiet_q <= quiet_q + 32'h1;
   end
   // A stream command arms the first-frame timer.
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !shutdown_n) armed_q <= 1'b0;
      else if (bus_valid) armed_q <= bus_stream;
      else if (frame_active) armed_q <= 1'b0;
   end
   // Elapsed cycles and the least wait of the command.
   always_ff @(posedge clk_sys) begin
      if (!reset_n || bus_valid) wait_q <= '0;
      else wait_q <= wait_q + 32'h1;
   end
   always_ff @(posedge clk_sys) begin
      if (bus_valid) lim_q <= FIXED_CYC + 32'(bus_expo) * LINE_LEN;
   end

   // ==========================================================================
   // Properties.
   // ==========================================================================
   sequence s_stream_cmd;
      bus_valid && bus_stream;
   endsequence
   sequence s_first_frame;
      armed_q && $rose(frame_active);
   endsequence

   a_bus_single_pulse: assert property (bus_valid |=> !bus_valid)
      else $error("bus request longer than one cycle");
   a_boot_wait_met: assert property (bus_valid |-> boot_q >= BOOT_CYC - 1)
      else $error("bus request before the boot wait ended");
   a_quiet_before_off: assert property ($fell(shutdown_n) |-> quiet_q >= QUIET_CYC - 1)
      else $error("shutdown fell too soon after activity");
   a_clock_kept_on: assert property (!ref_clk_en |-> quiet_q >= QUIET_CYC - 1)
      else $error("reference clock stopped too soon after activity");
   a_bus_link_alive: assert property (bus_valid |-> shutdown_n && powerdown_n && ref_clk_en)
      else $error("bus request while the device is held off");
   a_one_pin_driven: assert property (shutdown_n |-> powerdown_n)
      else $error("power-down pin low while shutdown is the driven pin");
   a_frame_not_early: assert property (s_first_frame |-> wait_q >= lim_q)
      else $error("first frame started before the stream wait");
   a_frame_not_late: assert property (armed_q |-> wait_q <= lim_q + LATE_SLACK)
      else $error("first frame started far after the stream wait");
   a_stream_hold: assert property (s_stream_cmd |=> !$rose(frame_active) [*8])
      else $error("frame started right after the stream command");
   a_frame_end_pulse: assert property (frame_end |=> !frame_end)
      else $error("frame end longer than one cycle");
   a_off_no_frames: assert property (!shutdown_n [*4] |-> !frame_active && !frame_end)
      else $error("frame activity while shutdown is held");
endmodule // spss_assertions
`default_nettype wire

//--- test/sensor_power_standby_sequencer_tb_top.sv
// Self-checking bench joining the host end and the sensor end over the link.
`timescale 1ns/10ps
`default_nettype none
module sensor_power_standby_sequencer_tb_top
   import spss_pkg::*;
;
   // Short counts keep the run brief.
   localparam int BOOT = 40;
   localparam int QUIET = 8;
   localparam int FIXED = 50;
   localparam int LINE = 4;
   logic        clk_sys;
   logic        reset_n;
   logic        supplies_ok;
   logic        power_on;
   logic        req_valid;
   logic        req_stream;
   logic [1:0]  req_gpio;
   logic [15:0] req_expo;
   logic        req_ready;
   logic        core_supply_ok;
   logic        streaming;
   logic        sw_standby;
   logic        hw_standby;
   logic        regs_default;
   logic        gpio_o;
   logic        gpio_oe;
   logic [1:0]  mode_q;
   logic [1:0]  exp_q[$];
   logic [31:0] lfsr_q = 32'h3D9C95E7;
   int          miscompares = 0;
   int          tests_run = 0;
   int          waited;
   int          fe_cnt = 0;
   int          fe0;
   int          lim;
   logic [15:0] ex;
   spss_gpio_t  gm;

   spss_if lnk ();
   spss_host #(.BOOT_CYC(BOOT), .QUIET_CYC(QUIET)) u_spss_host (
      .clk_sys(clk_sys), .reset_n(reset_n), .lnk(lnk), .supplies_ok(supplies_ok),
      .power_on(power_on), .req_valid(req_valid), .req_stream(req_stream),
      .req_gpio(req_gpio), .req_expo(req_expo), .req_ready(req_ready));
   spss_dev #(.FIXED_CYC(FIXED), .LINE_LEN(LINE), .FRAME_LINES(4)) u_spss_dev (
      .clk_sys(clk_sys), .reset_n(reset_n), .lnk(lnk), .core_supply_ok(core_supply_ok),
      .streaming(streaming), .sw_standby(sw_standby), .hw_standby(hw_standby),
      .regs_default(regs_default), .gpio_o(gpio_o), .gpio_oe(gpio_oe));
   spss_assertions #(.BOOT_CYC(BOOT), .QUIET_CYC(QUIET), .FIXED_CYC(FIXED),
      .LINE_LEN(LINE)) u_spss_assertions (
      .clk_sys(clk_sys), .reset_n(reset_n), .shutdown_n(lnk.shutdown_n),
      .powerdown_n(lnk.powerdown_n), .ref_clk_en(lnk.ref_clk_en), .bus_valid(lnk.bus_valid),
      .bus_stream(lnk.bus_stream), .bus_gpio(lnk.bus_gpio), .bus_expo(lnk.bus_expo),
      .frame_active(lnk.frame_active), .frame_end(lnk.frame_end));

   // ==========================================================================
   // Clock, checks and monitors.
   // ==========================================================================
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic fail(input string msg);
      miscompares++;
      $display("BAD %0t %s", $time, msg);
   endtask
   task automatic check_bit(input logic got, input logic exp, input string msg);
      tests_run++;
      if (got !== exp) fail(msg);
   endtask
   task automatic check_mode(input logic [1:0] got, input logic [1:0] exp);
      tests_run++;
      if (got !== exp) fail("standby mode differs");
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   function automatic logic sel_sig(input int sel);
      case (sel)
         0: return req_ready;
         1: return lnk.frame_active;
         2: return sw_standby;
         default: return hw_standby;
      endcase
   endfunction
   // Random words.
   function automatic logic [31:0] rnd();
      lfsr_q = {lfsr_q[30:0], ^(lfsr_q & 32'h80200003)};
      return lfsr_q;
   endfunction
   // Bounded wait for a level; a spent bound is a mismatch and ends the run.
   task automatic wait_hi(input int sel, input int lim_cyc);
      waited = 0;
      forever begin
         @(posedge clk_sys);
         waited++;
         if (sel_sig(sel) === 1'b1) return;
         if (waited >= lim_cyc) begin
            fail("wait ran out");
            complete_run();
         end
      end
   endtask
   // Request held from a falling edge until the edge that samples ready high.
   task automatic send(input logic strm, input spss_gpio_t g, input logic [15:0] e);
      @(negedge clk_sys);
      req_valid = 1'b1;
      req_stream = strm;
      req_gpio = g;
      req_expo = e;
      wait_hi(0, 400);
      @(negedge clk_sys);
      req_valid = 1'b0;
      {req_stream, req_gpio} = 3'(rnd());
   endtask
   // Scoreboard: each change of the standby mode takes the oldest note.
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         mode_q <= 2'h1;
      end else if ({sw_standby, hw_standby} !== mode_q) begin
         mode_q <= {sw_standby, hw_standby};
         if (exp_q.size() == 0) fail("unexpected mode change");
         else check_mode({sw_standby, hw_standby}, exp_q.pop_front());
      end
      if (lnk.frame_end === 1'b1) fe_cnt <= fe_cnt + 1;
   end
   // Watchdog so that a stuck sequence still reaches the report.
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail("run too long");
      complete_run();
   end

   // ==========================================================================
   // Main sequence.
   // ==========================================================================
   initial begin
      reset_n = 1'b0;
      supplies_ok = 1'b0;
      core_supply_ok = 1'b0;
      power_on = 1'b0;
      req_valid = 1'b0;
      req_stream = 1'b0;
      req_gpio = 2'h0;
      req_expo = 16'h0000;
      repeat (20) @(negedge clk_sys);
      reset_n = 1'b1;
      // Power up: the device makes its own reset and lands in software standby.
      exp_q.push_back(2'h2);
      supplies_ok = 1'b1;
      core_supply_ok = 1'b1;
      power_on = 1'b1;
      wait_hi(2, 300);
      wait_hi(0, 400);
      $display("test power_up done");
      // Standby pin modes, accepted over the bus while in software standby.
      for (int m = 0; m < 3; m++) begin
         gm = spss_gpio_t'(m);
         send(1'b0, gm, EXPO_RST);
         repeat (6) @(posedge clk_sys);
         check_bit(gpio_oe, gm != SPSS_GPIO_FLOAT, "pin enable");
         if (gm != SPSS_GPIO_FLOAT) check_bit(gpio_o, gm == SPSS_GPIO_HIGH, "pin level");
      end
      $display("test standby_pin done");
      // Stream entry with a random exposure: fixed wait plus exposure lines.
      ex = 16'(rnd() & 32'h7) + 16'h0001;
      lim = FIXED + int'(ex) * LINE;
      exp_q.push_back(2'h0);
      send(1'b1, SPSS_GPIO_FLOAT, ex);
      wait_hi(1, lim + 100);
      check_bit(waited >= lim && waited <= lim + 2 * LINE + 16, 1'b1, "first frame time");
      check_bit(streaming, 1'b1, "not streaming");
      $display("test stream_entry done");
      // Stop while a frame is out: standby only after its frame end.
      fe0 = fe_cnt;
      exp_q.push_back(2'h2);
      send(1'b0, SPSS_GPIO_FLOAT, ex);
      wait_hi(2, 100);
      check_bit(fe_cnt > fe0, 1'b1, "standby before frame end");
      $display("test stop_mid_frame done");
      // Stop between frames, during the entry wait: standby at once.
      exp_q.push_back(2'h0);
      send(1'b1, SPSS_GPIO_FLOAT, 16'h0001);
      repeat (10) @(posedge clk_sys);
      exp_q.push_back(2'h2);
      send(1'b0, SPSS_GPIO_FLOAT, 16'h0001);
      wait_hi(2, 8);
      check_bit(lnk.frame_active, 1'b0, "frame after stop");
      $display("test stop_between done");
      // Power off: quiet time, then shutdown resets every register.
      exp_q.push_back(2'h1);
      @(negedge clk_sys);
      power_on = 1'b0;
      wait_hi(3, 300);
      repeat (3) @(posedge clk_sys);
      check_bit(regs_default, 1'b1, "registers not default");
      check_bit(streaming, 1'b0, "streaming in shutdown");
      $display("test shutdown done");
      complete_run();
   end
endmodule // sensor_power_standby_sequencer_tb_top
`default_nettype wire
